//--- rtl/fault_supervisor_pkg.sv
package fault_supervisor_pkg;
	// clock: 40 MHz
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned LINK_DELAY_S = 30;
	localparam int unsigned FALLBACK_RETURN_S = 10;
	// catch-up factor 2.5 kept as 5/2
	localparam int unsigned CATCHUP_NUM = 5;
	localparam int unsigned CATCHUP_DEN = 2;
	localparam int unsigned PULSE_MS = 500;
	localparam int unsigned PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
	localparam logic [6:0] TAP_ERROR_CODE = 7'h63;
	localparam logic [3:0] BCD_EIGHT_FOUR = 4'hc;
	localparam int unsigned BLINK_CYCLES = CLK_HZ / 4;
	localparam logic [1:0] DIR_UP = 2'h1;
	localparam logic [1:0] DIR_DOWN = 2'h2;
endpackage

//--- rtl/regulator_fault_supervisor.sv
// Function
// (RQ1) link fault only when parallel or tracker active
// (RQ2) link fault delayed, adjustable, default 30s
// (RQ3) expansion check only when monitoring enabled
// (RQ4) service LED blinks during expansion fault
// (RQ5) expansion fault clears when configuration matches
// (RQ6) runtime fault when in-operation exceeds maximum
// (RQ7) steady runtime output while unacknowledged
// (RQ8) runtime ack: manual-auto, good tap, key
// (RQ9) still running after ack: refault after maximum
// (RQ10) pulsed runtime output for breaker trip
// (RQ11) tap fault: wrong direction, multi-step, none
// (RQ12) tap fault ack: manual-auto or key
// (RQ13) position 99 on invalid decode
// (RQ14) real position returns once decode valid
// (RQ15) group fault: follower misses 2.5x window
// (RQ16) catch-up window multiple after parallel start
// (RQ17) group fault on circulating current or difference
// (RQ18) group ack: manual-auto or parallel disabled
// (RQ19) group fault forces manual mode
// (RQ20) switch fault when open equals closed
// (RQ21) switch fault clears when inputs consistent
// (RQ22) fallback flag on peer loss, clears 10s after; code sets it only on peer loss with parallel and minimisation both on
// (RQ23) count, address, type mismatch is expansion fault
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_supervisor #(
	parameter int unsigned TICK_CYCLES = fault_supervisor_pkg::CLK_HZ,
	parameter int unsigned N_SWITCH = 4,
	parameter int unsigned CFG_W = 16
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// operating state
	input wire logic i_auto_mode,
	input wire logic i_parallel_on,
	input wire logic i_tracker_on,
	input wire logic i_master_follower,
	input wire logic i_minimisation,
	input wire logic i_regulator_view,
	input wire logic i_acknowledge_key,
	// peer link and expansion port
	input wire logic i_regulator_link_ok,
	input wire logic [CFG_W-1:0] i_expansion_port_cfg,
	// drive and tap feedback
	input wire logic i_drive_in_operation,
	input wire logic i_tap_cmd,
	input wire logic [1:0] i_tap_cmd_dir,
	input wire logic i_tap_settled,
	input wire logic [6:0] i_tap_decoded,
	input wire logic [3:0] i_bcd_low_digit,
	input wire logic i_current_out_of_limits,
	input wire logic i_resistance_too_high,
	input wire logic [6:0] i_master_tap,
	input wire logic i_circ_current_over,
	input wire logic i_tap_diff_over,
	// switch feedback
	input wire logic [N_SWITCH-1:0] i_breaker_position_input,
	input wire logic [N_SWITCH-1:0] i_breaker_open_input,
	// fault outputs
	output logic o_link_loss_fault,
	output logic o_expansion_port_fault,
	output logic o_service_led,
	output logic o_drive_runtime_fault,
	output logic o_drive_fault_steady_out,
	output logic o_drive_fault_pulse_out,
	output logic o_tap_step_fault,
	output logic [6:0] o_tap_position,
	output logic o_parallel_group_fault,
	output logic o_force_manual,
	output logic [N_SWITCH-1:0] o_switch_feedback_fault,
	output logic o_fallback_program_active
);
	// =========================================
	// register map
	localparam logic [3:0] A_LINK_DELAY = 4'h0;
	localparam logic [3:0] A_MAX_RUN = 4'h1;
	localparam logic [3:0] A_START_MULT = 4'h2;
	localparam logic [3:0] A_EXP_CTRL = 4'h3;
	localparam logic [3:0] A_STATUS = 4'h4;
	localparam logic [3:0] A_TAP = 4'h5;
	localparam logic [15:0] MAX_RUN_RESET = 16'h000a;
	localparam logic [15:0] START_MULT_RESET = 16'h0005;
	logic tick;
	second_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.o_tick(tick)
	);

	logic [15:0] link_delay;
	logic [15:0] max_run;
	logic [15:0] start_mult;
	logic exp_monitor;
	logic [CFG_W-1:0] exp_target;
	logic exp_set;
	assign exp_set = i_wr && (i_addr == A_EXP_CTRL) && i_wdata[1];
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			link_delay <= 16'(fault_supervisor_pkg::LINK_DELAY_S); // [RQ2]
			max_run <= MAX_RUN_RESET;
			start_mult <= START_MULT_RESET;
			exp_monitor <= 1'b0;
		end else if (i_wr) begin
			case (i_addr)
				A_LINK_DELAY: link_delay <= i_wdata;
				A_MAX_RUN: max_run <= i_wdata;
				A_START_MULT: start_mult <= i_wdata;
				A_EXP_CTRL: exp_monitor <= i_wdata[0] | i_wdata[1]; // target loads same edge
				default: ;
			endcase
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			exp_target <= '0;
		end else if (exp_set) begin
			exp_target <= i_expansion_port_cfg;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_rdata <= 16'h0;
		end else if (i_rd) begin
			case (i_addr)
				A_LINK_DELAY: o_rdata <= link_delay;
				A_MAX_RUN: o_rdata <= max_run;
				A_START_MULT: o_rdata <= start_mult;
				A_EXP_CTRL: o_rdata <= {15'h0, exp_monitor};
				A_STATUS: o_rdata <= {6'h0, o_fallback_program_active, |o_switch_feedback_fault,
					o_force_manual, o_parallel_group_fault, o_tap_step_fault,
					o_drive_runtime_fault, o_expansion_port_fault, o_link_loss_fault,
					i_regulator_link_ok, i_drive_in_operation};
				A_TAP: o_rdata <= {9'h0, o_tap_position};
				default: o_rdata <= 16'h0;
			endcase
		end else begin
			o_rdata <= 16'h0;
		end
	end

	// =========================================
	// common acknowledge events
	logic auto_d;
	always_ff @(posedge i_ref_clk) begin
		auto_d <= i_auto_mode; // no reset: avoids a false manual-to-auto edge
	end
	logic to_auto;
	logic key_ack;
	assign to_auto = i_auto_mode & ~auto_d;
	assign key_ack = i_acknowledge_key & i_regulator_view;

	// =========================================
	// link loss
	logic [15:0] link_secs;
	logic link_watch;
	assign link_watch = i_parallel_on | i_tracker_on; // [RQ1]
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !link_watch || i_regulator_link_ok) begin
			link_secs <= 16'h0;
			o_link_loss_fault <= 1'b0;
		end else if (link_secs >= link_delay) begin
			o_link_loss_fault <= 1'b1; // [RQ2]
		end else if (tick) begin
			link_secs <= link_secs + 16'h1;
		end
	end

	// =========================================
	// expansion port
	logic [24:0] blink_cnt;
	logic blink;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_expansion_port_fault <= 1'b0;
		end else begin
			o_expansion_port_fault <= exp_monitor && (i_expansion_port_cfg != exp_target); // [RQ3] [RQ5] [RQ23]
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || blink_cnt == 25'(fault_supervisor_pkg::BLINK_CYCLES - 1)) begin
			blink_cnt <= 25'h0;
		end else begin
			blink_cnt <= blink_cnt + 25'h1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			blink <= 1'b1; // lit from reset, so a fault soon after reset shows at once; a later one may wait up to half a period
		end else if (blink_cnt == 25'(fault_supervisor_pkg::BLINK_CYCLES - 1)) begin
			blink <= ~blink;
		end
	end
	assign o_service_led = o_expansion_port_fault & blink; // [RQ4]

	// =========================================
	// drive runtime
	logic [15:0] run_secs;
	logic good_step;
	logic [25:0] pulse_cnt;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !i_drive_in_operation) begin
			run_secs <= 16'h0;
		end else if (run_secs >= max_run) begin
			run_secs <= 16'h0; // restart so refault needs a further full time [RQ9]
		end else if (tick) begin
			run_secs <= run_secs + 16'h1;
		end
	end
	logic run_over;
	assign run_over = i_drive_in_operation && run_secs >= max_run; // [RQ6]
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_drive_runtime_fault <= 1'b0;
		end else if (run_over) begin
			o_drive_runtime_fault <= 1'b1; // set wins over ack
		end else if (to_auto || good_step || key_ack) begin
			o_drive_runtime_fault <= 1'b0; // [RQ8]
		end
	end
	assign o_drive_fault_steady_out = o_drive_runtime_fault; // [RQ7]
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pulse_cnt <= 26'h0;
		end else if (run_over) begin
			pulse_cnt <= 26'(fault_supervisor_pkg::PULSE_CYCLES); // [RQ10]
		end else if (pulse_cnt != 26'h0) begin
			pulse_cnt <= pulse_cnt - 26'h1;
		end
	end
	assign o_drive_fault_pulse_out = (pulse_cnt != 26'h0);

	// =========================================
	// tap step check and position decode
	logic pos_bad;
	logic [6:0] pos_at_cmd;
	logic pending;
	logic step_bad;
	assign pos_bad = ((i_bcd_low_digit & fault_supervisor_pkg::BCD_EIGHT_FOUR)
		== fault_supervisor_pkg::BCD_EIGHT_FOUR) | i_current_out_of_limits
		| i_resistance_too_high; // [RQ13]
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_tap_position <= 7'h0;
		end else begin
			o_tap_position <= pos_bad ? fault_supervisor_pkg::TAP_ERROR_CODE : i_tap_decoded; // [RQ14]
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pending <= 1'b0;
			pos_at_cmd <= 7'h0;
		end else if (i_tap_cmd) begin
			pending <= 1'b1;
			pos_at_cmd <= o_tap_position;
		end else if (i_tap_settled) begin
			pending <= 1'b0;
		end
	end
	always_comb begin
		step_bad = 1'b1;
		if (i_tap_cmd_dir == fault_supervisor_pkg::DIR_UP) begin
			step_bad = (o_tap_position != pos_at_cmd + 7'h1);
		end else if (i_tap_cmd_dir == fault_supervisor_pkg::DIR_DOWN) begin
			step_bad = (o_tap_position != pos_at_cmd - 7'h1);
		end
	end
	assign good_step = pending & i_tap_settled & ~step_bad;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_tap_step_fault <= 1'b0;
		end else if (pending && i_tap_settled && step_bad) begin
			o_tap_step_fault <= 1'b1; // [RQ11]
		end else if (to_auto || key_ack) begin
			o_tap_step_fault <= 1'b0; // [RQ12]
		end
	end

	// =========================================
	// parallel group
	logic par_d;
	logic just_started;
	logic [19:0] catch_secs;
	logic [19:0] window;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			par_d <= 1'b0;
			just_started <= 1'b0;
		end else begin
			par_d <= i_parallel_on;
			if (i_parallel_on && !par_d) begin
				just_started <= 1'b1;
			end else if (i_tap_decoded == i_master_tap) begin
				just_started <= 1'b0;
			end
		end
	end
	always_comb begin
		if (just_started) begin
			window = 20'(start_mult * max_run); // [RQ16]
		end else begin
			window = 20'((max_run * fault_supervisor_pkg::CATCHUP_NUM)
				/ fault_supervisor_pkg::CATCHUP_DEN); // [RQ15]
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !i_parallel_on || !i_master_follower || i_tap_decoded == i_master_tap) begin
			catch_secs <= 20'h0;
		end else if (tick && catch_secs <= window) begin
			catch_secs <= catch_secs + 20'h1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_parallel_group_fault <= 1'b0;
		end else if (i_parallel_on && ((catch_secs > window)
			|| (i_master_follower && i_circ_current_over)
			|| (i_minimisation && i_tap_diff_over))) begin
			o_parallel_group_fault <= 1'b1; // [RQ15] [RQ17]
		end else if (to_auto || !i_parallel_on) begin
			o_parallel_group_fault <= 1'b0; // [RQ18]
		end
	end
	assign o_force_manual = o_parallel_group_fault; // [RQ19]

	// =========================================
	// switch feedback, one lane per switch
	genvar g;
	generate
		for (g = 0; g < N_SWITCH; g++) begin : g_sw
			always_ff @(posedge i_ref_clk) begin
				if (i_srst) begin
					o_switch_feedback_fault[g] <= 1'b0;
				end else begin
					o_switch_feedback_fault[g] <= ~(i_breaker_position_input[g]
						^ i_breaker_open_input[g]); // [RQ20] [RQ21]
				end
			end
		end
	endgenerate

	// =========================================
	// fallback program
	logic [15:0] back_secs;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_fallback_program_active <= 1'b0;
			back_secs <= 16'h0;
		end else if (i_parallel_on && i_minimisation && !i_regulator_link_ok) begin
			o_fallback_program_active <= 1'b1; // [RQ22]
			back_secs <= 16'h0;
		end else if (o_fallback_program_active) begin
			if (back_secs >= 16'(fault_supervisor_pkg::FALLBACK_RETURN_S)) begin
				o_fallback_program_active <= 1'b0; // [RQ22]
			end else if (tick) begin
				back_secs <= back_secs + 16'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/second_tick.sv
`timescale 1ns/1ps
`default_nettype none
module second_tick #(
	parameter int unsigned CYCLES = 40000000
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// tick
	output logic o_tick
);
	logic [31:0] count;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || count == CYCLES - 1) begin
			count <= 32'h0;
		end else begin
			count <= count + 32'h1;
		end
	end
	assign o_tick = (count == CYCLES - 1);
endmodule
`default_nettype wire

//--- testbench/fault_supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor_props #(
	parameter int unsigned TICK_CYCLES = 40000000,
	parameter int unsigned N_SWITCH = 4
) (
	// clock, reset, inputs
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_parallel_on,
	input wire logic i_tracker_on,
	input wire logic i_regulator_link_ok,
	input wire logic i_drive_in_operation,
	input wire logic [3:0] i_bcd_low_digit,
	input wire logic [N_SWITCH-1:0] i_breaker_position_input,
	input wire logic [N_SWITCH-1:0] i_breaker_open_input,
	// outputs
	input wire logic o_link_loss_fault,
	input wire logic o_expansion_port_fault,
	input wire logic o_service_led,
	input wire logic o_drive_runtime_fault,
	input wire logic o_drive_fault_steady_out,
	input wire logic [6:0] o_tap_position,
	input wire logic o_parallel_group_fault,
	input wire logic o_force_manual,
	input wire logic [N_SWITCH-1:0] o_switch_feedback_fault
);
	// ==========
	// watched loss length; default delay only, 29 s floor allows tick phase
	localparam logic [31:0] LOSS_MIN = 29 * TICK_CYCLES;
	logic [31:0] loss_cnt;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || i_regulator_link_ok || !(i_parallel_on || i_tracker_on)) begin
			loss_cnt <= 32'h0;
		end else if (loss_cnt != 32'hffffffff) begin
			loss_cnt <= loss_cnt + 32'h1;
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	property p_link_gate;
		$rose(o_link_loss_fault) |-> $past(i_parallel_on || i_tracker_on);
	endproperty
	a_link_gate: assert property (p_link_gate) else $error("link fault while unused");
	property p_link_delay;
		$rose(o_link_loss_fault) |-> (loss_cnt >= LOSS_MIN);
	endproperty
	a_link_delay: assert property (p_link_delay) else $error("link fault too early");
	property p_led;
		!o_expansion_port_fault |-> !o_service_led;
	endproperty
	a_led: assert property (p_led) else $error("led active without fault");
	property p_run_cause;
		$rose(o_drive_runtime_fault) |-> $past(i_drive_in_operation);
	endproperty
	a_run_cause: assert property (p_run_cause) else $error("runtime fault without run");
	property p_steady;
		o_drive_fault_steady_out == o_drive_runtime_fault;
	endproperty
	a_steady: assert property (p_steady) else $error("steady output mismatch");
	property p_tap99;
		((i_bcd_low_digit & 4'hc) == 4'hc) |=> o_tap_position == 7'h63;
	endproperty
	a_tap99: assert property (p_tap99) else $error("bad decode not flagged");
	property p_manual;
		o_parallel_group_fault |-> o_force_manual;
	endproperty
	a_manual: assert property (p_manual) else $error("group fault without manual");
	property p_switch;
		1'b1 |=> o_switch_feedback_fault == $past(i_breaker_position_input ~^ i_breaker_open_input);
	endproperty
	a_switch: assert property (p_switch) else $error("switch fault wrong");
endmodule
bind regulator_fault_supervisor fault_supervisor_props #(
	.TICK_CYCLES(TICK_CYCLES),
	.N_SWITCH(N_SWITCH)
) u_props (.i_ref_clk, .i_srst, .i_parallel_on, .i_tracker_on, .i_regulator_link_ok,
	.i_drive_in_operation, .i_bcd_low_digit, .i_breaker_position_input, .i_breaker_open_input,
	.o_link_loss_fault, .o_expansion_port_fault, .o_service_led, .o_drive_runtime_fault,
	.o_drive_fault_steady_out, .o_tap_position, .o_parallel_group_fault, .o_force_manual,
	.o_switch_feedback_fault);
`default_nettype wire

//--- testbench/tap_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module tap_drive_model (
	// clock and command
	input wire logic i_ref_clk,
	input wire logic i_cmd,
	input wire logic [1:0] i_dir,
	// 0 good, 1 wrong way, 2 stuck running, 3 no move
	input wire logic [1:0] i_mode,
	// feedback
	output logic o_in_op,
	output logic [6:0] o_tap,
	output logic o_settled
);
	// ==========
	// motor run of five cycles, then position; settle pulse a cycle later
	logic [2:0] cnt;
	logic done;
	initial begin
		done = 1'b0;
		o_in_op = 1'b0;
		o_tap = 7'h05;
		o_settled = 1'b0;
		cnt = 3'h0;
	end
	always @(posedge i_ref_clk) begin
		o_settled <= done;
		done <= 1'b0;
		if (i_cmd) begin
			o_in_op <= 1'b1;
			cnt <= 3'h4;
		end else if (o_in_op && i_mode != 2'h2) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h0) begin
				o_in_op <= 1'b0;
				done <= 1'b1;
				if (i_mode != 2'h3) begin
					o_tap <= ((i_dir == fault_supervisor_pkg::DIR_UP) ^ i_mode[0]) ? o_tap + 7'h1 : o_tap - 7'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========
	// signals
	logic clk, srst, wr_s, rd_s, auto_m, par_on, mf, mini, view, key, lok;
	logic cur_bad, res_bad, circ, cmd, in_op, settled, trk, tdiff;
	logic [1:0] dir, mode;
	logic [3:0] addr, bcd, sw_pos, sw_open, sw_flt;
	logic [6:0] tap, pos, mofs;
	logic [15:0] wd, rdata, cfg;
	logic link_f, exp_f, led, run_f, steady, pulse, step_f, grp_f, man_f, fb_f;
	int fails, num_checks, cyc_cnt;
	// ==========
	// design and drive model
	regulator_fault_supervisor #(.TICK_CYCLES(10)) u_regulator_fault_supervisor (
		.i_ref_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata), .i_auto_mode(auto_m), .i_parallel_on(par_on), .i_tracker_on(trk),
		.i_master_follower(mf), .i_minimisation(mini), .i_regulator_view(view),
		.i_acknowledge_key(key), .i_regulator_link_ok(lok), .i_expansion_port_cfg(cfg),
		.i_drive_in_operation(in_op), .i_tap_cmd(cmd), .i_tap_cmd_dir(dir), .i_tap_settled(settled),
		.i_tap_decoded(tap), .i_bcd_low_digit(bcd), .i_current_out_of_limits(cur_bad),
		.i_resistance_too_high(res_bad), .i_master_tap(tap ^ mofs), .i_circ_current_over(circ),
		.i_tap_diff_over(tdiff), .i_breaker_position_input(sw_pos), .i_breaker_open_input(sw_open),
		.o_link_loss_fault(link_f), .o_expansion_port_fault(exp_f), .o_service_led(led),
		.o_drive_runtime_fault(run_f), .o_drive_fault_steady_out(steady),
		.o_drive_fault_pulse_out(pulse), .o_tap_step_fault(step_f), .o_tap_position(pos),
		.o_parallel_group_fault(grp_f), .o_force_manual(man_f), .o_switch_feedback_fault(sw_flt),
		.o_fallback_program_active(fb_f));
	tap_drive_model u_tap_drive_model (.i_ref_clk(clk), .i_cmd(cmd), .i_dir(dir), .i_mode(mode),
		.o_in_op(in_op), .o_tap(tap), .o_settled(settled));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ==========
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk) {addr, wd, wr_s} <= {a, d, 1'b1};
		@(posedge clk) wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk) {addr, rd_s} <= {a, 1'b1};
		@(posedge clk) rd_s <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic step(input logic [1:0] d, input logic [1:0] m);
		@(posedge clk) {dir, mode, cmd} <= {d, m, 1'b1};
		@(posedge clk) cmd <= 1'b0;
	endtask
	task automatic press(input logic v);
		@(posedge clk) {view, key} <= {v, 1'b1};
		@(posedge clk) key <= 1'b0;
		cyc(2);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_regs;
		rd(4'h0, 16'h001e);
		rd(4'h1, 16'h000a);
		rd(4'h3, 16'h0000);
		wr(4'hf, 16'hffff);
		rd(4'hf, 16'h0000);
		rd(4'h4, 16'h0002);
		rd(4'h5, 16'h0005);
	endtask
	task automatic t_link;
		@(posedge clk) lok <= 1'b0;
		cyc(400);
		chk(link_f, 1'b0);
		@(posedge clk) {par_on, mini} <= 2'h3;
		cyc(250);
		chk(link_f, 1'b0);
		for (int k = 0; k < 100 && link_f !== 1'b1; k++) cyc(1);
		chk(link_f, 1'b1);
		chk(fb_f, 1'b1);
		@(posedge clk) lok <= 1'b1;
		cyc(80);
		chk(fb_f, 1'b1);
		for (int k = 0; k < 40 && fb_f !== 1'b0; k++) cyc(1);
		chk(fb_f, 1'b0);
		@(posedge clk) {par_on, mini, lok, trk} <= 4'h1;
		for (int k = 0; k < 330 && link_f !== 1'b1; k++) cyc(1);
		chk(link_f, 1'b1);
		chk(fb_f, 1'b0);
		@(posedge clk) {lok, trk} <= 2'h2;
	endtask
	task automatic t_run;
		step(fault_supervisor_pkg::DIR_UP, 2'h2);
		cyc(80);
		chk(run_f, 1'b0);
		for (int k = 0; k < 40 && run_f !== 1'b1; k++) cyc(1);
		chk(run_f, 1'b1);
		chk(steady, 1'b1);
		chk(pulse, 1'b1);
		press(1'b1);
		chk(run_f, 1'b0);
		for (int k = 0; k < 120 && run_f !== 1'b1; k++) cyc(1);
		chk(run_f, 1'b1);
		@(posedge clk) mode <= 2'h0;
		cyc(10);
		chk(run_f, 1'b0);
		chk(step_f, 1'b0);
	endtask
	task automatic t_step;
		for (int m = 1; m < 4; m += 2) begin
			step(fault_supervisor_pkg::DIR_DOWN, 2'(m));
			cyc(10);
			chk(step_f, 1'b1);
			press(1'b0);
			@(posedge clk) auto_m <= 1'b0;
			cyc(2);
			chk(step_f, 1'b1);
			@(posedge clk) auto_m <= 1'b1;
			cyc(2);
			chk(step_f, 1'b0);
		end
	endtask
	task automatic t_misc;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) {bcd, cur_bad, res_bad} <= {(k == 0) ? 4'hc : 4'h5, k == 1, k == 2};
			cyc(2);
			chk(pos, fault_supervisor_pkg::TAP_ERROR_CODE);
		end
		@(posedge clk) res_bad <= 1'b0;
		cyc(2);
		chk(pos, 7'h07);
		@(posedge clk) sw_open <= 4'h9;
		cyc(2);
		chk(sw_flt, 4'h3);
		@(posedge clk) sw_open <= 4'ha;
		cyc(2);
		chk(sw_flt, 4'h0);
	endtask
	task automatic t_exp;
		@(posedge clk) cfg <= 16'h1234;
		wr(4'h3, 16'h0002);
		@(posedge clk) cfg <= 16'h1334;
		cyc(2);
		chk(exp_f, 1'b1);
		chk(led, 1'b1);
		@(posedge clk) cfg <= 16'h1234;
		cyc(2);
		chk(exp_f, 1'b0);
		chk(led, 1'b0);
		wr(4'h3, 16'h0000);
		@(posedge clk) cfg <= 16'h0000;
		cyc(2);
		chk(exp_f, 1'b0);
	endtask
	task automatic t_group;
		@(posedge clk) {mf, par_on, circ} <= 3'h7;
		cyc(3);
		chk(grp_f, 1'b1);
		chk(man_f, 1'b1);
		@(posedge clk) {circ, par_on} <= 2'h0;
		cyc(3);
		chk(grp_f, 1'b0);
		@(posedge clk) {mini, par_on, tdiff, auto_m} <= 4'he;
		cyc(3);
		chk(grp_f, 1'b1);
		@(posedge clk) tdiff <= 1'b0;
		cyc(2);
		chk(grp_f, 1'b1);
		@(posedge clk) auto_m <= 1'b1;
		cyc(2);
		chk(grp_f, 1'b0);
		// follower misses the master: steady window 2.5 x 10 s
		@(posedge clk) {mini, mofs} <= {1'b0, 7'h1};
		cyc(240);
		chk(grp_f, 1'b0);
		for (int k = 0; k < 60 && grp_f !== 1'b1; k++) cyc(1);
		chk(grp_f, 1'b1);
		@(posedge clk) par_on <= 1'b0;
		cyc(2);
		chk(grp_f, 1'b0);
		// fresh start: 5 x 10 s window outlasts the steady one
		@(posedge clk) par_on <= 1'b1;
		cyc(300);
		chk(grp_f, 1'b0);
		for (int k = 0; k < 260 && grp_f !== 1'b1; k++) cyc(1);
		chk(grp_f, 1'b1);
		@(posedge clk) {mf, par_on, mofs} <= 9'h0;
	endtask
	// ==========
	// sequence and hang guard
	initial begin
		{wr_s, rd_s, par_on, mf, mini, view, key, cur_bad, res_bad, circ, cmd, trk, tdiff} = 13'h0;
		mofs = 7'h0;
		{srst, auto_m, lok, addr, wd, cfg, dir, mode} = {3'h7, 40'h0};
		{bcd, sw_pos, sw_open} = 12'h55a;
		{fails, num_checks, cyc_cnt} = '0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_link();
		t_run();
		t_step();
		t_misc();
		t_exp();
		t_group();
		tally_and_finish();
	end
	// whole run is near 2200 cycles
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 6000) begin
			fails++;
			tally_and_finish();
		end
	end
endmodule
`default_nettype wire
